//--- inc/thermal_event_pin_event_pkg.sv
// constants for the thermal event monitor
package thermal_event_pin_event_pkg;
	// register offsets
	localparam logic [7:0] OFS_REMOTE1_CHANNEL_CONFIG = 8'h5F;
	localparam logic [7:0] OFS_LOCAL_CHANNEL_CONFIG = 8'h60;
	localparam logic [7:0] OFS_REMOTE2_CHANNEL_CONFIG = 8'h61;
	localparam logic [7:0] OFS_ACOUSTIC_ENHANCE_ONE = 8'h62;
	localparam logic [7:0] OFS_REMOTE1_CRITICAL_LIMIT = 8'h6A;
	localparam logic [7:0] OFS_LOCAL_CRITICAL_LIMIT = 8'h6B;
	localparam logic [7:0] OFS_REMOTE2_CRITICAL_LIMIT = 8'h6C;
	localparam logic [7:0] OFS_ALERT_MASK_TWO = 8'h75;
	localparam logic [7:0] OFS_CONFIGURATION_THREE = 8'h78;
	localparam logic [7:0] OFS_EVENT_TIMER = 8'h79;
	localparam logic [7:0] OFS_EVENT_TIME_LIMIT = 8'h7A;
	localparam logic [7:0] OFS_CONFIGURATION_FOUR = 8'h7D;
	// field positions
	localparam int BIT_CHANNEL_PIN_DRIVE = 3;
	localparam int BIT_TACH_SYNC_TO_DRIVE2 = 4;
	localparam int BIT_MASK_EVENT_LIMIT = 5;
	localparam int BIT_MONITOR_ENABLE = 1;
	localparam int BIT_FULL_SPEED_ON_EVENT = 2;
	localparam int BIT_EVENT_PIN_SELECT = 1;
	// reset, timer saturation and fan duty values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] TIMER_FULL = 8'hFF;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] DUTY_OFF = 8'h00;
	// timer resolution
	localparam real TICK_TIME_MS = 22.76;
	localparam real CLOCK_PERIOD_NS = 10.0;
	localparam int TICK_CYCLES_DFLT = int'(TICK_TIME_MS * 1.0e6 / CLOCK_PERIOD_NS);
	localparam int PRESCALE_W = 22;
	// channels and sync codes
	localparam int NUM_TEMP_CH = 3;
	localparam int NUM_EVENT_PINS = 2;
	localparam logic [1:0] SYNC_DRIVE_1 = 2'h1;
	localparam logic [1:0] SYNC_DRIVE_2 = 2'h2;
	localparam logic [1:0] SYNC_DRIVE_3 = 2'h3;
endpackage : thermal_event_pin_event_pkg

//--- logic/event_pin_sync.sv
// two flip-flop synchroniser for the event pin inputs
`timescale 1ns/1ns
module event_pin_sync
	import thermal_event_pin_event_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// raw and synchronised levels
	input wire logic [NUM_EVENT_PINS-1:0] i_level,
	output logic [NUM_EVENT_PINS-1:0] o_level
);
	logic [NUM_EVENT_PINS-1:0] meta_r;

	genvar g;
	generate
		for (g = 0; g < NUM_EVENT_PINS; g++) begin : g_bit
			// idle high so a reset never looks like an event
			always_ff @(posedge i_clock) begin
				if (i_rst) begin
					meta_r[g] <= 1'b1;
					o_level[g] <= 1'b1;
				end else begin
					meta_r[g] <= i_level[g];
					o_level[g] <= meta_r[g];
				end
			end
		end
	endgenerate
endmodule : event_pin_sync

//--- logic/critical_trip.sv
// per channel critical over-temperature trip with hold between samples
`timescale 1ns/1ns
module critical_trip
	import thermal_event_pin_event_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// configuration
	input wire logic i_enable,
	input wire logic [7:0] i_limit,
	// measurement, 0.25 degree steps, new value on i_sample
	input wire logic [9:0] i_temp,
	input wire logic i_sample,
	// trip state
	output logic o_trip
);
	// trip only when at least one quarter degree above the limit
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_trip <= 1'b0;
		end else if (!i_enable) begin
			o_trip <= 1'b0;
		end else if (i_sample) begin
			o_trip <= (i_temp > {i_limit, 2'b00});
		end
	end
endmodule : critical_trip

//--- logic/thermal_event_pin_event_monitor.sv
// thermal event timer, limit alert, fan override and pin drive
//
// Behaviour
// - eight-bit writable limit covering first assertion up to 5.804 seconds.
// - timer above limit sets the limit flag and raises the alert.
// - mask bit five blocks the alert; the flag still sets.
// - limit zero flags and alerts on the first detected assertion.
// - limit one alerts only after more than 45.52 ms accumulated.
// - monitoring runs only with its enable bit; default pin shares tach four.
// - pin select plus enable moves monitoring to alternate pin, frees tach four.
// - full-speed bit forces running fans to full duty during an event.
// - enabled channel a quarter degree over critical limit drives pin low, only while monitoring is enabled.
// - pin stays low until a measurement is at or below the limit.
// - three separate critical limits for remote one, local, remote two.
// - bit three of each channel config enables that channel's pin drive.
// - default sync: tach one to drive one, tach three and four to three.
// - acoustic bit four syncs tachs two, three, four to drive two.
// - timer runs while asserted, accumulates, clears on read, saturates.
// - bit zero sets on first assertion, then 22.76 ms resolution count.
// - read during assertion clears, sets bit zero again, counts from zero.
`timescale 1ns/1ns
module thermal_event_pin_event_monitor
	import thermal_event_pin_event_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [7:0] o_reg_rdata,
	// limit flag clear from the status logic
	input wire logic i_limit_flag_clear,
	output logic o_event_limit_flag,
	output logic o_alert,
	// default event pin, shared with fan speed input 4
	input wire logic i_pin14_in,
	output logic o_pin14_out,
	output logic o_pin14_oe_n,
	output logic o_fan_speed_input_4_free,
	// alternate event pin
	input wire logic i_pin20_in,
	output logic o_pin20_out,
	output logic o_pin20_oe_n,
	// temperature measurements
	input wire logic [NUM_TEMP_CH*10-1:0] i_temp,
	input wire logic [NUM_TEMP_CH-1:0] i_temp_sample,
	// fan drives
	input wire logic [7:0] i_fan_drive_duty_1,
	input wire logic [7:0] i_fan_drive_duty_2,
	input wire logic [7:0] i_fan_drive_duty_3,
	output logic [7:0] o_fan_drive_duty_1,
	output logic [7:0] o_fan_drive_duty_2,
	output logic [7:0] o_fan_drive_duty_3,
	output logic o_full_speed_on_event,
	// tach to fan drive sync selection
	output logic [1:0] o_fan_speed_sync_1,
	output logic [1:0] o_fan_speed_sync_2,
	output logic [1:0] o_fan_speed_sync_3,
	output logic [1:0] o_fan_speed_sync_4
);
	logic [7:0] channel_config_r [NUM_TEMP_CH];
	logic [7:0] critical_limit_r [NUM_TEMP_CH];
	logic [7:0] acoustic_enhance_one_r;
	logic [7:0] alert_mask_two_r;
	logic [7:0] configuration_three_r;
	logic [7:0] event_time_limit_r;
	logic [7:0] configuration_four_r;
	logic [7:0] timer_r;
	logic first_tick_done_r;
	logic [PRESCALE_W-1:0] prescale_r;
	logic [NUM_EVENT_PINS-1:0] pin_level;
	logic [NUM_TEMP_CH-1:0] trip;
	logic monitor_en;
	logic use_alt_pin;
	logic event_act;
	logic timer_read;
	logic tick;
	logic drive_low;
	logic [7:0] read_mux;

	// configuration decode
	assign monitor_en = configuration_three_r[BIT_MONITOR_ENABLE];
	assign use_alt_pin = monitor_en && configuration_four_r[BIT_EVENT_PIN_SELECT];
	assign timer_read = i_reg_read && (i_reg_addr == OFS_EVENT_TIMER);

	event_pin_sync u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_level({i_pin20_in, i_pin14_in}),
		.o_level(pin_level)
	);

	// active-low pin, only the selected one counts
	assign event_act = monitor_en && !(use_alt_pin ? pin_level[1] : pin_level[0]);

	genvar g;
	generate
		for (g = 0; g < NUM_TEMP_CH; g++) begin : g_ch
			critical_trip u_trip (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_enable(channel_config_r[g][BIT_CHANNEL_PIN_DRIVE]),
				.i_limit(critical_limit_r[g]),
				.i_temp(i_temp[g*10 +: 10]),
				.i_sample(i_temp_sample[g]),
				.o_trip(trip[g])
			);
		end
	endgenerate

	// drive only through the pin that holds the event function
	assign drive_low = monitor_en && (|trip);

	// register writes
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			for (int i = 0; i < NUM_TEMP_CH; i++) begin
				channel_config_r[i] <= REG_RESET;
				critical_limit_r[i] <= REG_RESET;
			end
			acoustic_enhance_one_r <= REG_RESET;
			alert_mask_two_r <= REG_RESET;
			configuration_three_r <= REG_RESET;
			event_time_limit_r <= REG_RESET;
			configuration_four_r <= REG_RESET;
		end else if (i_reg_write) begin
			case (i_reg_addr)
				OFS_REMOTE1_CHANNEL_CONFIG: channel_config_r[0] <= i_reg_wdata;
				OFS_LOCAL_CHANNEL_CONFIG: channel_config_r[1] <= i_reg_wdata;
				OFS_REMOTE2_CHANNEL_CONFIG: channel_config_r[2] <= i_reg_wdata;
				OFS_ACOUSTIC_ENHANCE_ONE: acoustic_enhance_one_r <= i_reg_wdata;
				OFS_REMOTE1_CRITICAL_LIMIT: critical_limit_r[0] <= i_reg_wdata;
				OFS_LOCAL_CRITICAL_LIMIT: critical_limit_r[1] <= i_reg_wdata;
				OFS_REMOTE2_CRITICAL_LIMIT: critical_limit_r[2] <= i_reg_wdata;
				OFS_ALERT_MASK_TWO: alert_mask_two_r <= i_reg_wdata;
				OFS_CONFIGURATION_THREE: configuration_three_r <= i_reg_wdata;
				OFS_EVENT_TIME_LIMIT: event_time_limit_r <= i_reg_wdata;
				OFS_CONFIGURATION_FOUR: configuration_four_r <= i_reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// register reads, unmapped offsets read zero
	always_comb begin
		case (i_reg_addr)
			OFS_REMOTE1_CHANNEL_CONFIG: read_mux = channel_config_r[0];
			OFS_LOCAL_CHANNEL_CONFIG: read_mux = channel_config_r[1];
			OFS_REMOTE2_CHANNEL_CONFIG: read_mux = channel_config_r[2];
			OFS_ACOUSTIC_ENHANCE_ONE: read_mux = acoustic_enhance_one_r;
			OFS_REMOTE1_CRITICAL_LIMIT: read_mux = critical_limit_r[0];
			OFS_LOCAL_CRITICAL_LIMIT: read_mux = critical_limit_r[1];
			OFS_REMOTE2_CRITICAL_LIMIT: read_mux = critical_limit_r[2];
			OFS_ALERT_MASK_TWO: read_mux = alert_mask_two_r;
			OFS_CONFIGURATION_THREE: read_mux = configuration_three_r;
			OFS_EVENT_TIMER: read_mux = timer_r;
			OFS_EVENT_TIME_LIMIT: read_mux = event_time_limit_r;
			OFS_CONFIGURATION_FOUR: read_mux = configuration_four_r;
			default: read_mux = REG_RESET;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_reg_rdata <= REG_RESET;
		end else if (i_reg_read) begin
			o_reg_rdata <= read_mux;
		end
	end

	// resolution prescaler, runs only while asserted, keeps partial time
	assign tick = event_act && (prescale_r == PRESCALE_W'(TICK_CYCLES - 1));

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			prescale_r <= '0;
		end else if (timer_read) begin
			prescale_r <= '0;
		end else if (tick) begin
			prescale_r <= '0;
		end else if (event_act) begin
			prescale_r <= prescale_r + 1'b1;
		end
	end

	// bit zero marks any assertion; count takes over at the second tick
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			timer_r <= REG_RESET;
			first_tick_done_r <= 1'b0;
		end else if (timer_read) begin
			timer_r <= event_act ? 8'h01 : REG_RESET;
			first_tick_done_r <= 1'b0;
		end else if (tick) begin
			first_tick_done_r <= 1'b1;
			if (!first_tick_done_r) begin
				timer_r <= 8'h01;
			end else if (timer_r != TIMER_FULL) begin
				timer_r <= (timer_r == 8'h01) ? 8'h02 : timer_r + 8'h01;
			end
		end else if (event_act && (timer_r == REG_RESET)) begin
			timer_r <= 8'h01;
		end
	end

	// limit flag: a set in the clear cycle wins
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_event_limit_flag <= 1'b0;
		end else if (monitor_en && (timer_r > event_time_limit_r)) begin
			o_event_limit_flag <= 1'b1;
		end else if (i_limit_flag_clear) begin
			o_event_limit_flag <= 1'b0;
		end
	end

	// alert follows the flag, masking never touches the flag itself
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_alert <= 1'b0;
		end else begin
			o_alert <= o_event_limit_flag && !alert_mask_two_r[BIT_MASK_EVENT_LIMIT];
		end
	end

	// pin function and open-drain drive
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_pin14_out <= 1'b0;
			o_pin20_out <= 1'b0;
			o_pin14_oe_n <= 1'b1;
			o_pin20_oe_n <= 1'b1;
			o_fan_speed_input_4_free <= 1'b1;
		end else begin
			o_pin14_out <= 1'b0;
			o_pin20_out <= 1'b0;
			o_pin14_oe_n <= !(drive_low && !use_alt_pin);
			o_pin20_oe_n <= !(drive_low && use_alt_pin);
			o_fan_speed_input_4_free <= !monitor_en || use_alt_pin;
		end
	end

	// a stopped fan stays stopped, so override only running drives
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_full_speed_on_event <= 1'b0;
			o_fan_drive_duty_1 <= DUTY_OFF;
			o_fan_drive_duty_2 <= DUTY_OFF;
			o_fan_drive_duty_3 <= DUTY_OFF;
		end else begin
			o_full_speed_on_event <= event_act && configuration_three_r[BIT_FULL_SPEED_ON_EVENT];
			o_fan_drive_duty_1 <= (o_full_speed_on_event && i_fan_drive_duty_1 != DUTY_OFF) ?
				DUTY_FULL : i_fan_drive_duty_1;
			o_fan_drive_duty_2 <= (o_full_speed_on_event && i_fan_drive_duty_2 != DUTY_OFF) ?
				DUTY_FULL : i_fan_drive_duty_2;
			o_fan_drive_duty_3 <= (o_full_speed_on_event && i_fan_drive_duty_3 != DUTY_OFF) ?
				DUTY_FULL : i_fan_drive_duty_3;
		end
	end

	// tach sync selection
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_fan_speed_sync_1 <= SYNC_DRIVE_1;
			o_fan_speed_sync_2 <= SYNC_DRIVE_2;
			o_fan_speed_sync_3 <= SYNC_DRIVE_3;
			o_fan_speed_sync_4 <= SYNC_DRIVE_3;
		end else if (acoustic_enhance_one_r[BIT_TACH_SYNC_TO_DRIVE2]) begin
			o_fan_speed_sync_1 <= SYNC_DRIVE_1;
			o_fan_speed_sync_2 <= SYNC_DRIVE_2;
			o_fan_speed_sync_3 <= SYNC_DRIVE_2;
			o_fan_speed_sync_4 <= SYNC_DRIVE_2;
		end else begin
			o_fan_speed_sync_1 <= SYNC_DRIVE_1;
			o_fan_speed_sync_2 <= SYNC_DRIVE_2;
			o_fan_speed_sync_3 <= SYNC_DRIVE_3;
			o_fan_speed_sync_4 <= SYNC_DRIVE_3;
		end
	end

	// checks
	a_flag_on_exceed: assert property (@(posedge i_clock) disable iff (i_rst)
		monitor_en && (timer_r > event_time_limit_r) |=> o_event_limit_flag
		##1 (o_alert || $past(alert_mask_two_r[BIT_MASK_EVENT_LIMIT])))
		else $error("limit flag or alert missed");

	a_alert_masked: assert property (@(posedge i_clock) disable iff (i_rst)
		alert_mask_two_r[BIT_MASK_EVENT_LIMIT] |=> !o_alert)
		else $error("alert raised while masked");

	a_zero_limit_first: assert property (@(posedge i_clock) disable iff (i_rst)
		$rose(event_act) && event_time_limit_r == 8'h00 && !i_reg_write |-> ##[1:2] o_event_limit_flag)
		else $error("zero limit did not flag first assertion");

	a_limit_one_wait: assert property (@(posedge i_clock) disable iff (i_rst)
		event_time_limit_r == 8'h01 && timer_r <= 8'h01 && !o_event_limit_flag && !i_reg_write
		|=> !o_event_limit_flag)
		else $error("limit one flagged before two ticks");

	a_monitor_off: assert property (@(posedge i_clock) disable iff (i_rst)
		!monitor_en && !timer_read && !i_reg_write |=> $stable(timer_r) && !o_full_speed_on_event)
		else $error("timer moved while monitoring disabled");

	a_pin_select: assert property (@(posedge i_clock) disable iff (i_rst)
		use_alt_pin |=> o_fan_speed_input_4_free && o_pin14_oe_n)
		else $error("tach four pin not freed");

	a_full_duty: assert property (@(posedge i_clock) disable iff (i_rst)
		o_full_speed_on_event && i_fan_drive_duty_1 != DUTY_OFF |=> o_fan_drive_duty_1 == DUTY_FULL)
		else $error("running fan not forced to full duty");

	a_stopped_fan_kept: assert property (@(posedge i_clock) disable iff (i_rst)
		o_full_speed_on_event && i_fan_drive_duty_2 == DUTY_OFF |=> o_fan_drive_duty_2 == DUTY_OFF)
		else $error("stopped fan started by an event");

	a_duty_follow: assert property (@(posedge i_clock) disable iff (i_rst)
		!o_full_speed_on_event |=> o_fan_drive_duty_1 == $past(i_fan_drive_duty_1))
		else $error("fan duty changed without an event");

	a_pin_hold_low: assert property (@(posedge i_clock) disable iff (i_rst)
		drive_low && !use_alt_pin && i_temp_sample == '0 && $stable(monitor_en) && !i_reg_write
		|=> ##1 !o_pin14_oe_n)
		else $error("event pin released between samples");

	a_timer_saturate: assert property (@(posedge i_clock) disable iff (i_rst)
		timer_r == TIMER_FULL && !timer_read |=> timer_r == TIMER_FULL)
		else $error("saturated timer changed");

	a_read_rearm: assert property (@(posedge i_clock) disable iff (i_rst)
		timer_read |=> timer_r == ($past(event_act) ? 8'h01 : 8'h00))
		else $error("timer read did not clear properly");

	a_sync_to_two: assert property (@(posedge i_clock) disable iff (i_rst)
		acoustic_enhance_one_r[BIT_TACH_SYNC_TO_DRIVE2] |=> o_fan_speed_sync_3 == SYNC_DRIVE_2
		&& o_fan_speed_sync_4 == SYNC_DRIVE_2)
		else $error("tach sync not moved to drive two");

	a_alt_pin_drive: assert property (@(posedge i_clock) disable iff (i_rst)
		drive_low && use_alt_pin |=> !o_pin20_oe_n && o_pin14_oe_n)
		else $error("alternate event pin not driven");
endmodule : thermal_event_pin_event_monitor

//--- test/event_source.sv
// far-side event source: open-drain event lines with pull-ups
`timescale 1ns/1ns
module event_source (
	// requests from the bench in place of the processor hot output
	input wire logic i_assert_14,
	input wire logic i_assert_20,
	// device drive of each pin
	input wire logic i_pin14_out,
	input wire logic i_pin14_oe_n,
	input wire logic i_pin20_out,
	input wire logic i_pin20_oe_n,
	// resolved wire levels
	output logic o_pin14,
	output logic o_pin20
);
	// wired-and: either party pulls low, the pull-up wins when both release
	assign o_pin14 = !i_assert_14 && (i_pin14_oe_n || i_pin14_out);
	assign o_pin20 = !i_assert_20 && (i_pin20_oe_n || i_pin20_out);
endmodule : event_source

//--- test/thermal_event_pin_event_monitor_bench.sv
// testbench for the thermal event monitor
`timescale 1ns/1ns
module thermal_event_pin_event_monitor_bench;
	import thermal_event_pin_event_pkg::*;
	// short tick keeps the saturation run to a few thousand cycles
	localparam int TICKS = 8;
	logic i_clock, i_rst, i_reg_write, i_reg_read, i_limit_flag_clear, ast14, ast20;
	logic i_pin14_in, i_pin20_in, o_pin14_out, o_pin14_oe_n, o_pin20_out, o_pin20_oe_n;
	logic o_event_limit_flag, o_alert, o_fan_speed_input_4_free, o_full_speed_on_event;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic [7:0] i_fan_drive_duty_1, i_fan_drive_duty_2, i_fan_drive_duty_3;
	logic [7:0] o_fan_drive_duty_1, o_fan_drive_duty_2, o_fan_drive_duty_3;
	logic [29:0] i_temp;
	logic [2:0] i_temp_sample;
	logic [1:0] o_fan_speed_sync_1, o_fan_speed_sync_2, o_fan_speed_sync_3, o_fan_speed_sync_4;
	int err_count, checks;
	// rows: offset, write value, expected read back
	logic [23:0] rows [13] = '{24'h5FA5A5, 24'h605A5A, 24'h613C3C, 24'h62C3C3, 24'h6A8181, 24'h6B7E7E,
		24'h6C1111, 24'h75EEEE, 24'h78F0F0, 24'h7AFFFF, 24'h7D4444, 24'h10FF00, 24'h795500};

	thermal_event_pin_event_monitor #(.TICK_CYCLES(TICKS)) thermal_event_pin_event_monitor_inst (.i_clock, .i_rst, .i_reg_addr,
		.i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_limit_flag_clear, .o_event_limit_flag,
		.o_alert, .i_pin14_in, .o_pin14_out, .o_pin14_oe_n, .o_fan_speed_input_4_free, .i_pin20_in,
		.o_pin20_out, .o_pin20_oe_n, .i_temp, .i_temp_sample, .i_fan_drive_duty_1, .i_fan_drive_duty_2,
		.i_fan_drive_duty_3, .o_fan_drive_duty_1, .o_fan_drive_duty_2, .o_fan_drive_duty_3,
		.o_full_speed_on_event, .o_fan_speed_sync_1, .o_fan_speed_sync_2, .o_fan_speed_sync_3,
		.o_fan_speed_sync_4);
	event_source event_source_inst (.i_assert_14(ast14), .i_assert_20(ast20), .i_pin14_out(o_pin14_out),
		.i_pin14_oe_n(o_pin14_oe_n), .i_pin20_out(o_pin20_out), .i_pin20_oe_n(o_pin20_oe_n),
		.o_pin14(i_pin14_in), .o_pin20(i_pin20_in));

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	task automatic wrap_up();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : step
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask : chk1
	task automatic chk_sync(input logic [7:0] exp);
		chk8({o_fan_speed_sync_4, o_fan_speed_sync_3, o_fan_speed_sync_2, o_fan_speed_sync_1}, exp);
	endtask : chk_sync
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_write = 1'b1;
		step(1);
		i_reg_write = 1'b0;
		// idle edge so a following write never re-raises the strobe in the same time step
		step(1);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		i_reg_addr = a;
		i_reg_read = 1'b1;
		step(1);
		i_reg_read = 1'b0;
		chk8(o_reg_rdata, exp);
		step(1);
	endtask : rdc
	task automatic clr_flag();
		i_limit_flag_clear = 1'b1;
		step(1);
		i_limit_flag_clear = 1'b0;
	endtask : clr_flag
	// hold pin14 low for n cycles, then release and let the synchroniser settle
	task automatic pulse14(input int n);
		ast14 = 1'b1;
		step(n);
		ast14 = 1'b0;
		step(4);
	endtask : pulse14
	task automatic trip(input int ch, input logic [9:0] t, input logic exp_oe_n);
		i_temp[ch*10 +: 10] = t;
		i_temp_sample[ch] = 1'b1;
		step(1);
		i_temp_sample = 3'h0;
		step(2);
		chk1(o_pin14_oe_n, exp_oe_n);
	endtask : trip
	task automatic wait_flag();
		int n;
		n = 0;
		while (o_event_limit_flag !== 1'b1 && n < 50) begin
			step(1);
			n++;
		end
		if (n == 50) begin
			err_count++;
			wrap_up();
		end
	endtask : wait_flag

	initial begin
		{i_reg_write, i_reg_read, i_limit_flag_clear, ast14, ast20, i_temp_sample} = '0;
		i_rst = 1'b1;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		i_temp = '0;
		i_fan_drive_duty_1 = 8'h40;
		i_fan_drive_duty_2 = 8'h00;
		i_fan_drive_duty_3 = 8'h80;
		step(3);
		i_rst = 1'b0;
		chk_sync(8'hF9);
		chk1(o_fan_speed_input_4_free, 1'b1);
		chk1(o_pin14_oe_n, 1'b1);
		for (int i = 0; i < 13; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rdc(rows[i][23:16], rows[i][7:0]);
			wr(rows[i][23:16], 8'h00);
		end
		// tach sync moves to drive 2, then a mid-run reset restores defaults
		wr(OFS_ACOUSTIC_ENHANCE_ONE, 8'h10);
		step(1);
		chk_sync(8'hA9);
		i_rst = 1'b1;
		step(1);
		i_rst = 1'b0;
		chk_sync(8'hF9);
		// monitoring disabled: timer frozen, no override
		pulse14(20);
		rdc(OFS_EVENT_TIMER, 8'h00);
		// limit zero: first assertion flags and alerts
		wr(OFS_EVENT_TIME_LIMIT, 8'h00);
		wr(OFS_CONFIGURATION_THREE, 8'h02);
		step(1);
		chk1(o_fan_speed_input_4_free, 1'b0);
		ast14 = 1'b1;
		wait_flag();
		step(1);
		chk1(o_alert, 1'b1);
		rdc(OFS_EVENT_TIMER, 8'h01);
		rdc(OFS_EVENT_TIMER, 8'h01);
		ast14 = 1'b0;
		step(4);
		rdc(OFS_EVENT_TIMER, 8'h01);
		// limit one with mask: accumulate two short events across the second tick
		wr(OFS_EVENT_TIME_LIMIT, 8'h01);
		wr(OFS_ALERT_MASK_TWO, 8'h20);
		clr_flag();
		step(1);
		chk1(o_event_limit_flag, 1'b0);
		pulse14(10);
		chk1(o_event_limit_flag, 1'b0);
		pulse14(10);
		chk1(o_event_limit_flag, 1'b1);
		chk1(o_alert, 1'b0);
		rdc(OFS_EVENT_TIMER, 8'h02);
		wr(OFS_ALERT_MASK_TWO, 8'h00);
		step(2);
		chk1(o_alert, 1'b1);
		clr_flag();
		// full speed override, then hold low until the timer saturates
		wr(OFS_EVENT_TIME_LIMIT, 8'hFF);
		wr(OFS_CONFIGURATION_THREE, 8'h06);
		ast14 = 1'b1;
		step(5);
		chk1(o_full_speed_on_event, 1'b1);
		chk8(o_fan_drive_duty_1, DUTY_FULL);
		chk8(o_fan_drive_duty_2, DUTY_OFF);
		chk8(o_fan_drive_duty_3, DUTY_FULL);
		pulse14(2200);
		chk8(o_fan_drive_duty_1, 8'h40);
		rdc(OFS_EVENT_TIMER, TIMER_FULL);
		wr(OFS_CONFIGURATION_THREE, 8'h02);
		ast14 = 1'b1;
		step(5);
		chk8(o_fan_drive_duty_3, 8'h80);
		pulse14(1);
		// alternate pin takes over and tach four is freed
		wr(OFS_CONFIGURATION_FOUR, 8'h02);
		rdc(OFS_EVENT_TIMER, 8'h01);
		step(1);
		chk1(o_fan_speed_input_4_free, 1'b1);
		pulse14(20);
		rdc(OFS_EVENT_TIMER, 8'h00);
		ast20 = 1'b1;
		step(5);
		rdc(OFS_EVENT_TIMER, 8'h01);
		ast20 = 1'b0;
		wr(OFS_CONFIGURATION_FOUR, 8'h00);
		// critical trip per channel, each with its own limit and enable
		wr(OFS_REMOTE1_CRITICAL_LIMIT, 8'h30);
		wr(OFS_LOCAL_CRITICAL_LIMIT, 8'h20);
		wr(OFS_REMOTE2_CRITICAL_LIMIT, 8'h40);
		wr(OFS_LOCAL_CHANNEL_CONFIG, 8'h08);
		wr(OFS_REMOTE2_CHANNEL_CONFIG, 8'h08);
		trip(1, 10'h081, 1'b0);
		trip(1, 10'h081, 1'b0);
		trip(1, 10'h080, 1'b1);
		trip(0, 10'h3FF, 1'b1);
		trip(2, 10'h100, 1'b1);
		trip(2, 10'h101, 1'b0);
		trip(2, 10'h000, 1'b1);
		chk1(o_pin14_out, 1'b0);
		// alternate pin carries the drive, default pin stays released
		wr(OFS_CONFIGURATION_FOUR, 8'h02);
		trip(2, 10'h101, 1'b1);
		chk1(o_pin20_oe_n, 1'b0);
		chk1(o_pin20_out, 1'b0);
		trip(2, 10'h000, 1'b1);
		chk1(o_pin20_oe_n, 1'b1);
		wrap_up();
	end
endmodule : thermal_event_pin_event_monitor_bench
